// >>> hdl/swc_defs.svh
// register offsets, field positions and reset values for the sleep and wake-up controller
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_OFF_GLOBAL_INT_CONTROL  12'h000
`define SWC_OFF_INT_ENABLE_1    12'h004
`define SWC_OFF_INT_ENABLE_2    12'h008
`define SWC_OFF_INT_ENABLE_3    12'h00c
`define SWC_OFF_INT_ENABLE_4    12'h010
`define SWC_OFF_INT_ENABLE_5    12'h014
`define SWC_OFF_PENDING_FLAGS_1    12'h018
`define SWC_OFF_PENDING_FLAGS_2    12'h01c
`define SWC_OFF_PENDING_FLAGS_3    12'h020
`define SWC_OFF_PENDING_FLAGS_4    12'h024
`define SWC_OFF_PENDING_FLAGS_5    12'h028
`define SWC_OFF_STATUS  12'h02c
`define SWC_OFF_VREG    12'h030
`define SWC_OFF_PEND    12'h034
`define SWC_MASK_PENDING_FLAGS_2   8'hef
`define SWC_MASK_PENDING_FLAGS_3   8'h3f
`define SWC_MASK_PENDING_FLAGS_5   8'hf7
`define SWC_MASK_GLOBAL_INT_CONTROL 8'hf8
`define SWC_SW_PENDING_FLAGS_5     8'hf3
`define SWC_BIT_GIE     7
`define SWC_BIT_PERIPHERAL_INT_ENABLE    6
`define SWC_BIT_TO      4
`define SWC_BIT_PD      3
`define SWC_BIT_REGULATOR_POWER_MODE  1
`define SWC_VREG_RST    8'h01
`define SWC_RESP_OKAY   2'b00
`define SWC_RESP_SLVERR 2'b10
`endif

// >>> hdl/swc_pkg.sv
// types for the sleep and wake-up controller
`default_nettype none
package swc_pkg;
    typedef enum logic [1:0] {
        SWC_RUN    = 2'b00,
        SWC_ENTER  = 2'b01,
        SWC_SLEEP  = 2'b11,
        SWC_RESUME = 2'b10
    } swc_state_t;

    // peripheral event pulses, one bit per flag position
    typedef struct packed {
        logic [7:0] pending_flags_1;
        logic [7:0] pending_flags_2;
        logic [7:0] pending_flags_3;
        logic [7:0] pending_flags_4;
        logic [7:0] pending_flags_5;
        logic [2:0] core;   // int0 edge, timer0, change-notify events
    } swc_events_t;

    // controls handed to clock, regulator, watchdog and core
    typedef struct packed {
        logic cpu_clk_en;
        logic lowpower_reg;
        logic wdt_clear;
        logic hold_io;
        logic resume_pulse;
        logic isr_call;
    } swc_ctrl_t;
endpackage : swc_pkg
`default_nettype wire

// >>> hdl/swc_sleep_ctrl.sv
// sleep entry, wake decision and interrupt request registers behind an AXI4-Lite slave
`include "swc_defs.svh"
`default_nettype none
module swc_sleep_ctrl (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // core side
    input  wire logic               sleep_exec,
    input  wire logic               clrwdt_exec,
    input  wire logic               wdt_sleep_en,
    input  wire logic               wdt_timeout,
    input  wire swc_pkg::swc_events_t periph_events,
    input  wire logic [7:0]         io_drive_in,
    input  wire logic [7:0]         io_oe_in,
    input  wire logic               external_reset_pin_n,
    input  wire logic               brownout_reset,
    output swc_pkg::swc_ctrl_t      ctrl,
    output logic                    low_freq_internal_osc_en,
    output logic                    timer1_ext_clock_pin_en,
    output logic                    adc_rc_osc_en,
    output logic                    prefetch_next,
    output logic                    sys_reset_req,
    output logic                    asleep,
    output logic [7:0]              io_drive_out,
    output logic [7:0]              io_oe_out
);
    import swc_pkg::*;

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    swc_state_t  state_ff;
    swc_state_t  nxt_state;
    logic [7:0]  global_int_control_ff;
    logic [7:0]  pie_ff   [1:5];
    logic [7:0]  pir_ff   [1:5];
    logic [7:0]  vreg_ff;
    logic        to_ff;
    logic        pd_ff;
    logic        gie_wake_ff;
    logic [7:0]  io_drive_ff;
    logic [7:0]  io_oe_ff;
    logic [1:0]  external_reset_pin_sync_ff;
    logic [1:0]  bor_sync_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        wr_fire;
    logic        wr_hit;
    logic [7:0]  wr_byte;
    logic [7:0]  per_req;
    logic        core_req;
    logic        wake_req;
    logic        ext_reset;
    logic [7:0]  rd_val;
    logic        rd_hit;

    // ----------------------------------------------------------------
    // wake decision
    // ----------------------------------------------------------------
    // each source is flag AND enable, peripherals also need PERIPHERAL_INT_ENABLE
    always_comb
    begin
        for (int i = 1; i <= 5; i++)
        begin
            per_req[i-1] = |(pir_ff[i] & pie_ff[i]);
        end
        per_req[7:5] = 3'h0;
        core_req = |(global_int_control_ff[5:3] & global_int_control_ff[2:0]);
        // GLOBAL_INT_ENABLE is not part of the wake term
        wake_req = core_req
                 | ((|per_req) & global_int_control_ff[`SWC_BIT_PERIPHERAL_INT_ENABLE]);
    end

    // reset pin and brown-out pass two flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            external_reset_pin_sync_ff <= 2'b11;
            bor_sync_ff  <= 2'b00;
        end
        else
        begin
            external_reset_pin_sync_ff <= {external_reset_pin_sync_ff[0], external_reset_pin_n};
            bor_sync_ff  <= {bor_sync_ff[0], brownout_reset};
        end
    end
    // reset sources act alike awake or asleep
    assign ext_reset = !external_reset_pin_sync_ff[1] | bor_sync_ff[1];

    // ----------------------------------------------------------------
    // sleep state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SWC_RUN:
                // only the sleep instruction enters; pending request makes it a no-op
                if (sleep_exec && !wake_req)
                    nxt_state = SWC_ENTER;
            SWC_ENTER:
                nxt_state = SWC_SLEEP;
            SWC_SLEEP:
                if (wake_req || (wdt_timeout && wdt_sleep_en))
                    nxt_state = SWC_RESUME;
            SWC_RESUME:
                nxt_state = SWC_RUN;
            default:
                nxt_state = SWC_RUN;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || ext_reset)
            state_ff <= SWC_RUN;
        else
            state_ff <= nxt_state;
    end

    // status bits: entry clears PD and sets TO
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            to_ff <= 1'b1;
            pd_ff <= 1'b1;
        end
        else if (state_ff == SWC_RUN && nxt_state == SWC_ENTER)
        begin
            to_ff <= 1'b1;
            pd_ff <= 1'b0;
        end
        else if (clrwdt_exec)
        begin
            to_ff <= 1'b1;
            pd_ff <= 1'b1;
        end
        else if (state_ff == SWC_SLEEP && wdt_timeout)
            to_ff <= 1'b0;
    end

    // pins frozen on entry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            io_drive_ff <= 8'h00;
            io_oe_ff    <= 8'h00;
        end
        else if (state_ff == SWC_RUN)
        begin
            io_drive_ff <= io_drive_in;
            io_oe_ff    <= io_oe_in;
        end
    end

    // remember GLOBAL_INT_ENABLE at wake for the service call
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            gie_wake_ff <= 1'b0;
        else if (state_ff == SWC_SLEEP)
            gie_wake_ff <= global_int_control_ff[`SWC_BIT_GIE];
    end

    // controls to clock, regulator and watchdog
    always_comb
    begin
        asleep                 = (state_ff == SWC_ENTER) || (state_ff == SWC_SLEEP);
        ctrl.cpu_clk_en        = !asleep;
        ctrl.lowpower_reg      = asleep && vreg_ff[`SWC_BIT_REGULATOR_POWER_MODE];
        ctrl.wdt_clear         = (state_ff == SWC_ENTER)
                               || (state_ff == SWC_RESUME);
        ctrl.hold_io           = asleep;
        ctrl.resume_pulse      = (state_ff == SWC_RESUME);
        ctrl.isr_call          = (state_ff == SWC_RESUME) && gie_wake_ff;
        low_freq_internal_osc_en = 1'b1;
        timer1_ext_clock_pin_en  = 1'b1;
        adc_rc_osc_en            = 1'b1;
        prefetch_next          = sleep_exec;
        sys_reset_req          = ext_reset;
        io_drive_out           = asleep ? io_drive_ff : io_drive_in;
        io_oe_out              = asleep ? io_oe_ff : io_oe_in;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_byte = wstrb_ff[0] ? wdata_ff[7:0] : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `SWC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_comb
    begin
        case (awaddr_ff)
            `SWC_OFF_GLOBAL_INT_CONTROL, `SWC_OFF_INT_ENABLE_1, `SWC_OFF_INT_ENABLE_2, `SWC_OFF_INT_ENABLE_3,
            `SWC_OFF_INT_ENABLE_4, `SWC_OFF_INT_ENABLE_5, `SWC_OFF_PENDING_FLAGS_1, `SWC_OFF_PENDING_FLAGS_2,
            `SWC_OFF_PENDING_FLAGS_3, `SWC_OFF_PENDING_FLAGS_4, `SWC_OFF_PENDING_FLAGS_5, `SWC_OFF_STATUS,
            `SWC_OFF_VREG, `SWC_OFF_PEND:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // control registers written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_int_control_ff <= 8'h00;
            vreg_ff   <= `SWC_VREG_RST;
            for (int i = 1; i <= 5; i++)
                pie_ff[i] <= 8'h00;
        end
        else
        begin
            if (wr_fire && awaddr_ff == `SWC_OFF_GLOBAL_INT_CONTROL)
                global_int_control_ff[7:3] <= wr_byte[7:3];
            // core event flags set by hardware, set wins over clear
            global_int_control_ff[2:0] <= ((wr_fire && awaddr_ff == `SWC_OFF_GLOBAL_INT_CONTROL)
                              ? wr_byte[2:0] : global_int_control_ff[2:0]) | periph_events.core;
            if (wr_fire && awaddr_ff == `SWC_OFF_VREG)
                vreg_ff <= {6'h00, wr_byte[`SWC_BIT_REGULATOR_POWER_MODE], 1'b1};
            if (wr_fire && awaddr_ff == `SWC_OFF_INT_ENABLE_1)
                pie_ff[1] <= wr_byte;
            if (wr_fire && awaddr_ff == `SWC_OFF_INT_ENABLE_2)
                pie_ff[2] <= wr_byte & `SWC_MASK_PENDING_FLAGS_2;
            if (wr_fire && awaddr_ff == `SWC_OFF_INT_ENABLE_3)
                pie_ff[3] <= wr_byte & `SWC_MASK_PENDING_FLAGS_3;
            if (wr_fire && awaddr_ff == `SWC_OFF_INT_ENABLE_4)
                pie_ff[4] <= wr_byte;
            if (wr_fire && awaddr_ff == `SWC_OFF_INT_ENABLE_5)
                pie_ff[5] <= wr_byte & `SWC_MASK_PENDING_FLAGS_5;
        end
    end

    // request flags: hardware set wins over software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 1; i <= 5; i++)
                pir_ff[i] <= 8'h00;
        end
        else
        begin
            pir_ff[1] <= ((wr_fire && awaddr_ff == `SWC_OFF_PENDING_FLAGS_1) ? wr_byte : pir_ff[1])
                       | periph_events.pending_flags_1;
            pir_ff[2] <= (((wr_fire && awaddr_ff == `SWC_OFF_PENDING_FLAGS_2) ? wr_byte : pir_ff[2])
                       | periph_events.pending_flags_2) & `SWC_MASK_PENDING_FLAGS_2;
            pir_ff[3] <= (((wr_fire && awaddr_ff == `SWC_OFF_PENDING_FLAGS_3) ? wr_byte : pir_ff[3])
                       | periph_events.pending_flags_3) & `SWC_MASK_PENDING_FLAGS_3;
            // bit7 scanner .. bit0 meas1 match
            pir_ff[4] <= ((wr_fire && awaddr_ff == `SWC_OFF_PENDING_FLAGS_4) ? wr_byte : pir_ff[4])
                       | periph_events.pending_flags_4;
            // angular flag keeps its value on writes, bit 3 forced zero
            pir_ff[5] <= (((wr_fire && awaddr_ff == `SWC_OFF_PENDING_FLAGS_5)
                        ? ((wr_byte & `SWC_SW_PENDING_FLAGS_5) | (pir_ff[5] & ~`SWC_SW_PENDING_FLAGS_5))
                        : pir_ff[5]) | periph_events.pending_flags_5) & `SWC_MASK_PENDING_FLAGS_5;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SWC_OFF_GLOBAL_INT_CONTROL: rd_val = global_int_control_ff;
            `SWC_OFF_INT_ENABLE_1:   rd_val = pie_ff[1];
            `SWC_OFF_INT_ENABLE_2:   rd_val = pie_ff[2];
            `SWC_OFF_INT_ENABLE_3:   rd_val = pie_ff[3];
            `SWC_OFF_INT_ENABLE_4:   rd_val = pie_ff[4];
            `SWC_OFF_INT_ENABLE_5:   rd_val = pie_ff[5];
            `SWC_OFF_PENDING_FLAGS_1:   rd_val = pir_ff[1];
            `SWC_OFF_PENDING_FLAGS_2:   rd_val = pir_ff[2];
            `SWC_OFF_PENDING_FLAGS_3:   rd_val = pir_ff[3];
            `SWC_OFF_PENDING_FLAGS_4:   rd_val = pir_ff[4];
            `SWC_OFF_PENDING_FLAGS_5:   rd_val = pir_ff[5];
            `SWC_OFF_STATUS: rd_val = {3'h0, to_ff, pd_ff, 3'h0};
            `SWC_OFF_VREG:   rd_val = vreg_ff;
            `SWC_OFF_PEND:   rd_val = {6'h00, asleep, wake_req};
            default:
            begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !rvalid_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `SWC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h000000, rd_val};
            rresp_ff  <= rd_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_NOP_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_RUN && sleep_exec && wake_req && !ext_reset)
            |=> (state_ff == SWC_RUN && $stable(pd_ff)))
        else $error("sleep with pending request did not act as no-op");
    AST_ENTRY_STATUS: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_ENTER) |-> (!pd_ff && to_ff && ctrl.wdt_clear))
        else $error("sleep entry did not update status");
    AST_ONLY_SLEEP_INSN: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_RUN && !sleep_exec) |=> (state_ff != SWC_ENTER))
        else $error("sleep entered without instruction");
    AST_CLK_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_SLEEP) |-> !ctrl.cpu_clk_en)
        else $error("cpu clock running in sleep");
    AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_SLEEP && wake_req && !ext_reset) |=> ctrl.resume_pulse)
        else $error("enabled request did not wake");
    AST_WDT_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.resume_pulse |-> ctrl.wdt_clear)
        else $error("watchdog not cleared on wake");
    AST_PENDING_FLAGS_5_BIT3: assert property (@(posedge aclk) disable iff (!aresetn)
        !pir_ff[5][3])
        else $error("reserved request bit set");
    AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        periph_events.pending_flags_4[7] |=> pir_ff[4][7])
        else $error("event did not set flag");
    AST_IO_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_SLEEP && $past(state_ff) == SWC_SLEEP) |-> $stable(io_oe_out))
        else $error("pins changed asleep");
    AST_LOWPWR: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SWC_SLEEP && vreg_ff[1]) |-> ctrl.lowpower_reg)
        else $error("regulator not in low power");
endmodule : swc_sleep_ctrl
`default_nettype wire

// >>> sim/swc_core_model.sv
// core and peripheral event source model for the sleep controller bench
`default_nettype none
module swc_core_model (
    input  wire logic                 aclk,
    input  wire logic                 sleep_cmd,
    input  wire swc_pkg::swc_events_t ev_cmd,
    output logic                      sleep_exec,
    output swc_pkg::swc_events_t      periph_events,
    output logic [7:0]                io_drive_in,
    output logic [7:0]                io_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    logic [7:0] pin_ff = 8'h00;
    // pins change every cycle so a frozen copy is visible
    always_ff @(posedge aclk)
    begin
        pin_ff <= pin_ff + 8'h01;
    end
    // sleep is only ever a one-cycle instruction strobe
    assign sleep_exec    = sleep_cmd;
    assign periph_events = ev_cmd;
    assign io_drive_in   = pin_ff;
    assign io_oe_in      = ~pin_ff;
endmodule : swc_core_model
`default_nettype wire

// >>> sim/test_swc_sleep_ctrl.sv
// self-checking bench for the sleep and wake-up controller
`include "swc_defs.svh"
`default_nettype none
module test_swc_sleep_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    logic        aclk, aresetn, sleep_cmd, clrwdt_exec, wdt_sleep_en, wdt_timeout;
    logic        external_reset_pin_n, brownout_reset, sleep_exec, asleep, sys_reset_req;
    logic        low_freq_internal_osc_en, timer1_ext_clock_pin_en, adc_rc_osc_en;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  io_drive_in, io_oe_in, io_drive_out, io_oe_out, h;
    logic [15:0] hio;
    logic        prefetch_next;
    logic        gie_x = 1'b0;  // global enable as last written by the bench
    swc_events_t periph_events, ev_cmd, ev;
    swc_ctrl_t   ctrl;
    logic [33:0] rq[$], bq[$];
    int          num_errors = 0;
    int          num_checks = 0;

    swc_sleep_ctrl u_swc_sleep_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sleep_exec, .clrwdt_exec, .wdt_sleep_en, .wdt_timeout, .periph_events,
        .io_drive_in, .io_oe_in, .external_reset_pin_n, .brownout_reset, .ctrl,
        .low_freq_internal_osc_en, .timer1_ext_clock_pin_en, .adc_rc_osc_en,
        .prefetch_next, .sys_reset_req, .asleep, .io_drive_out, .io_oe_out);
    swc_core_model u_swc_core_model (.aclk, .sleep_cmd, .ev_cmd, .sleep_exec,
        .periph_events, .io_drive_in, .io_oe_in);

    // -------------------------------------------------------------
    // clock, compare and closing
    // -------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // responses are compared at the low phase, before the taking edge
    always @(negedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", bq.pop_front(), {s_axi_bresp, 32'h0});
        if (sleep_exec)
            chk("prefetch", 34'h1, {33'h0, prefetch_next});
        if (ctrl.resume_pulse)
        begin
            chk("wake_wdt_clear", 34'h1, {33'h0, ctrl.wdt_clear});
            chk("isr_call", {33'h0, gie_x}, {33'h0, ctrl.isr_call});
        end
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        final_report();
    end

    // -------------------------------------------------------------
    // bus and core tasks
    // -------------------------------------------------------------
    function automatic logic pick(input int k);
        case (k)
            0: return s_axi_arready;
            1: return s_axi_rvalid;
            default: return s_axi_bvalid;
        endcase
    endfunction : pick
    // waits until the chosen signal is high at a rising edge
    task automatic wt(input int k);
        logic t;
        do
        begin
            @(negedge aclk);
            t = pick(k);
            @(posedge aclk);
        end while (!t);
    endtask : wt
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        bq.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(da && dw))
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end
        wt(2);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        rq.push_back({r, 24'h0, e});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        wt(0);
        s_axi_arvalid <= 1'b0;
        wt(1);
        s_axi_rready  <= 1'b0;
    endtask : rd
    // one-cycle strobes: bit 0 sleep, bit 1 clear watchdog, bit 2 watchdog expiry
    task automatic pulse(input logic [2:0] k, input swc_events_t e);
        @(posedge aclk);
        {wdt_timeout, clrwdt_exec, sleep_cmd} <= k;
        ev_cmd <= e;
        @(posedge aclk);
        {wdt_timeout, clrwdt_exec, sleep_cmd} <= 3'h0;
        ev_cmd <= '0;
    endtask : pulse
    task automatic wlv(input logic v);
        repeat (20) if (asleep !== v) @(posedge aclk);
        chk("asleep", {33'h0, v}, {33'h0, asleep});
    endtask : wlv

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        {aresetn, sleep_cmd, clrwdt_exec, wdt_sleep_en, wdt_timeout, brownout_reset} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        external_reset_pin_n = 1'b1;
        ev_cmd = '0;
        ev = '0;
        void'($urandom(57585));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SWC_OFF_PENDING_FLAGS_4, 8'h00, `SWC_RESP_OKAY);
        rd(`SWC_OFF_PENDING_FLAGS_5, 8'h00, `SWC_RESP_OKAY);
        rd(`SWC_OFF_STATUS, 8'h18, `SWC_RESP_OKAY);
        rd(`SWC_OFF_VREG, 8'h01, `SWC_RESP_OKAY);
        ev.pending_flags_4 = 8'($urandom);
        pulse(3'h0, ev);
        rd(`SWC_OFF_PENDING_FLAGS_4, ev.pending_flags_4, `SWC_RESP_OKAY);
        ev = '0;
        ev.pending_flags_5 = 8'hff;
        pulse(3'h0, ev);
        rd(`SWC_OFF_PENDING_FLAGS_5, 8'hf7, `SWC_RESP_OKAY);
        wr(`SWC_OFF_PENDING_FLAGS_5, 8'h00, `SWC_RESP_OKAY);
        rd(`SWC_OFF_PENDING_FLAGS_5, 8'h04, `SWC_RESP_OKAY);
        wr(`SWC_OFF_PENDING_FLAGS_4, 8'h00, `SWC_RESP_OKAY);
        rd(`SWC_OFF_PENDING_FLAGS_4, 8'h00, `SWC_RESP_OKAY);
        rd(12'h100, 8'h00, `SWC_RESP_SLVERR);
        wr(12'h100, 8'h5a, `SWC_RESP_SLVERR);
        wr(`SWC_OFF_VREG, 8'h03, `SWC_RESP_OKAY);
        wr(`SWC_OFF_INT_ENABLE_5, 8'h01, `SWC_RESP_OKAY);
        wr(`SWC_OFF_GLOBAL_INT_CONTROL, 8'h40, `SWC_RESP_OKAY);
        pulse(3'h1, '0);
        wlv(1'b1);
        rd(`SWC_OFF_STATUS, 8'h10, `SWC_RESP_OKAY);
        chk("cpu_clk_en", 34'h0, {33'h0, ctrl.cpu_clk_en});
        chk("lowpower", 34'h1, {33'h0, ctrl.lowpower_reg});
        chk("osc_en", 34'h7, {31'h0, low_freq_internal_osc_en,
            timer1_ext_clock_pin_en, adc_rc_osc_en});
        h = io_drive_out;
        hio = {io_oe_out, io_drive_out};
        repeat (3) @(posedge aclk);
        chk("io_hold", {26'h0, h}, {26'h0, io_drive_out});
        chk("io_oe_hold", {18'h0, hio}, {18'h0, io_oe_out, io_drive_out});
        chk("hold_io", 34'h1, {33'h0, ctrl.hold_io});
        ev = '0;
        ev.pending_flags_5 = 8'h01;
        pulse(3'h0, ev);
        wlv(1'b0);
        rd(`SWC_OFF_STATUS, 8'h10, `SWC_RESP_OKAY);
        pulse(3'h2, '0);
        pulse(3'h1, '0);
        repeat (3) @(posedge aclk);
        chk("noop_sleep", 34'h0, {33'h0, asleep});
        rd(`SWC_OFF_STATUS, 8'h18, `SWC_RESP_OKAY);
        wr(`SWC_OFF_PENDING_FLAGS_5, 8'h00, `SWC_RESP_OKAY);
        wdt_sleep_en <= 1'b1;
        pulse(3'h1, '0);
        wlv(1'b1);
        pulse(3'h4, '0);
        wlv(1'b0);
        external_reset_pin_n <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("reset_req", 34'h1, {33'h0, sys_reset_req});
        final_report();
    end
endmodule : test_swc_sleep_ctrl
`default_nettype wire
